// ===== hw/aao_core.sv
// AHB-Lite register front end and sequencer for the add/AND slice
`timescale 1ns/1ps
module aao_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Sequencer status
  output logic busy_o,
  output logic done_o
);

  // ==========================================================
  // State record
  typedef struct packed {
    aao_pkg::aao_seq_e seq;
    logic [7:0] opcode;
    logic [7:0] byte2;
    logic [7:0] byte3;
    logic [7:0] dst_val;
    logic [7:0] src_val;
    logic [7:0] flags;
    logic [7:0] result;
    logic [3:0] cnt;
    logic busy;
    logic done;
    logic illegal;
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } aao_state_s;

  aao_state_s state_q;
  aao_state_s state_d;

  // Decoder outputs
  logic dec_legal;
  aao_pkg::aao_op_e dec_op;
  aao_pkg::aao_mode_e dec_mode;
  logic [1:0] dec_len;
  logic [3:0] dec_cycles;
  logic [7:0] dec_dst_addr;
  logic [7:0] dec_src_addr;
  // Operand and ALU results
  logic [7:0] src_operand;
  logic [7:0] alu_result;
  logic [7:0] alu_flags;
  logic is_work;
  logic addr_phase;

  // ==========================================================
  // Decoder on the stored instruction bytes
  aao_decode u_decode (
    .opcode_i(state_q.opcode),
    .byte2_i(state_q.byte2),
    .byte3_i(state_q.byte3),
    .legal_o(dec_legal),
    .op_o(dec_op),
    .mode_o(dec_mode),
    .len_o(dec_len),
    .cycles_o(dec_cycles),
    .dst_addr_o(dec_dst_addr),
    .src_addr_o(dec_src_addr)
  );

  // Immediate form takes its source from the third byte
  assign src_operand = (dec_mode == aao_pkg::MODE_REG_IMM) ? state_q.byte3
                                                           : state_q.src_val;
  assign is_work = (dec_mode == aao_pkg::MODE_WORK_WORK) ||
                   (dec_mode == aao_pkg::MODE_WORK_IND);

  // ==========================================================
  // Combining logic
  aao_alu u_alu (
    .op_i(dec_op),
    .dst_i(state_q.dst_val),
    .src_i(src_operand),
    .flags_i(state_q.flags),
    .result_o(alu_result),
    .flags_o(alu_flags)
  );

  // ==========================================================
  // Address phase qualifier
  assign addr_phase = hsel_i && hready_i && htrans_i[1];

  // Read view of the register map
  function automatic logic [31:0] read_word(input aao_state_s s, input logic [7:0] addr,
                                            input logic [1:0] len, input logic [3:0] cyc,
                                            input logic work, input logic [7:0] da,
                                            input logic [7:0] sa);
    logic [31:0] w;
    w = aao_pkg::RST_WORD;
    case (addr)
      aao_pkg::OFS_CTRL: w = {24'h00_0000, s.opcode};
      aao_pkg::OFS_INSTR: w = {16'h0000, s.byte3, s.byte2};
      aao_pkg::OFS_OPND: w = {16'h0000, s.src_val, s.dst_val};
      aao_pkg::OFS_FLAGS: w = {24'h00_0000, s.flags};
      aao_pkg::OFS_RESULT: w = {24'h00_0000, s.result};
      aao_pkg::OFS_STATUS: begin
        w[aao_pkg::ST_BUSY_BIT] = s.busy;
        w[aao_pkg::ST_DONE_BIT] = s.done;
        w[aao_pkg::ST_ILL_BIT] = s.illegal;
        w[aao_pkg::ST_WORK_BIT] = work;
        w[5:4] = len;
        w[11:8] = cyc;
        w[23:16] = da;
        w[31:24] = sa;
      end
      default: w = aao_pkg::RST_WORD;
    endcase
    return w;
  endfunction

  // ==========================================================
  // Next-state logic: bus writes, sequencing, read data
  always_comb begin
    state_d = state_q;
    state_d.hreadyout = 1'b1;
    state_d.hresp = 1'b0; // Every answer is OKAY
    // Data phase of a word write; writes while busy are dropped
    if (state_q.dp_valid && state_q.dp_write && !state_q.busy) begin
      case (state_q.dp_addr)
        aao_pkg::OFS_CTRL: begin
          state_d.opcode = hwdata_i[7:0];
          if (hwdata_i[aao_pkg::CTRL_GO_BIT]) begin
            state_d.seq = aao_pkg::SEQ_EXEC;
            state_d.busy = 1'b1;
            state_d.done = 1'b0;
            state_d.illegal = 1'b0;
            state_d.cnt = 4'h1;
          end
        end
        aao_pkg::OFS_INSTR: begin
          state_d.byte2 = hwdata_i[7:0];
          state_d.byte3 = hwdata_i[15:8];
        end
        aao_pkg::OFS_OPND: begin
          state_d.dst_val = hwdata_i[7:0];
          state_d.src_val = hwdata_i[15:8];
        end
        aao_pkg::OFS_FLAGS: state_d.flags = hwdata_i[7:0];
        default: ;
      endcase
    end
    // Sequencer: hold busy for the decoded cycle count, or one cycle for an illegal opcode
    unique case (state_q.seq)
      aao_pkg::SEQ_IDLE: ;
      aao_pkg::SEQ_EXEC: begin
        if (!dec_legal) begin
          state_d.seq = aao_pkg::SEQ_IDLE;
          state_d.busy = 1'b0;
          state_d.done = 1'b1;
          state_d.illegal = 1'b1;
        end else if (state_q.cnt >= dec_cycles) begin
          state_d.seq = aao_pkg::SEQ_IDLE;
          state_d.busy = 1'b0;
          state_d.done = 1'b1;
          state_d.result = alu_result;
          state_d.dst_val = alu_result;
          state_d.flags = alu_flags;
        end else begin
          state_d.cnt = state_q.cnt + 4'h1;
        end
      end
    endcase
    // Capture the address phase
    state_d.dp_valid = addr_phase;
    state_d.dp_write = addr_phase && hwrite_i && (hsize_i == 3'h2);
    state_d.dp_addr = haddr_i[7:0];
    // Read data from the updated copy so a write just before is seen
    if (addr_phase && !hwrite_i) begin
      state_d.hrdata = read_word(state_d, haddr_i[7:0], dec_len, dec_cycles, is_work,
                                 dec_dst_addr, dec_src_addr);
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_q <= '0;
      state_q.seq <= aao_pkg::SEQ_IDLE;
      state_q.hreadyout <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Outputs straight from the state register
  assign hrdata_o = state_q.hrdata;
  assign hreadyout_o = state_q.hreadyout;
  assign hresp_o = state_q.hresp; // Always OKAY
  assign busy_o = state_q.busy;
  assign done_o = state_q.done;

endmodule

// ===== hw/aao_pkg.sv
// Shared constants and types for the add/AND datapath slice
package aao_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INSTR = 8'h04;
  localparam logic [7:0] OFS_OPND = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ==========================================================
  // Field positions
  localparam int CTRL_GO_BIT = 8;
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;
  localparam int FLG_D = 3;
  localparam int FLG_H = 2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_ILL_BIT = 2;
  localparam int ST_WORK_BIT = 3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ==========================================================
  // Opcodes, lengths and cycle counts
  localparam logic [3:0] GRP_ADD = 4'h0;
  localparam logic [3:0] GRP_AND = 4'h5;
  localparam logic [3:0] FORM_RR = 4'h2;
  localparam logic [3:0] FORM_RIR = 4'h3;
  localparam logic [3:0] FORM_GG = 4'h4;
  localparam logic [3:0] FORM_GIG = 4'h5;
  localparam logic [3:0] FORM_GIM = 4'h6;
  localparam logic [1:0] LEN_SHORT = 2'h2;
  localparam logic [1:0] LEN_LONG = 2'h3;
  localparam logic [3:0] CYC_SHORT = 4'h4;
  localparam logic [3:0] CYC_LONG = 4'h6;

  // ==========================================================
  // Types
  typedef enum logic {ALU_ADD, ALU_AND} aao_op_e;
  typedef enum logic [2:0] {
    MODE_WORK_WORK, MODE_WORK_IND, MODE_REG_REG, MODE_REG_IND, MODE_REG_IMM
  } aao_mode_e;
  typedef enum logic {SEQ_IDLE, SEQ_EXEC} aao_seq_e;

endpackage

// ===== hw/aao_decode.sv
// Opcode decoder: operation, addressing form, length, cycles, operand addresses
`timescale 1ns/1ps
module aao_decode (
  // Instruction bytes
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] byte2_i,
  input wire logic [7:0] byte3_i,
  // Decoded fields
  output logic legal_o,
  output aao_pkg::aao_op_e op_o,
  output aao_pkg::aao_mode_e mode_o,
  output logic [1:0] len_o,
  output logic [3:0] cycles_o,
  output logic [7:0] dst_addr_o,
  output logic [7:0] src_addr_o
);

  // ==========================================================
  // Operation group from the high nibble
  always_comb begin
    legal_o = 1'b1;
    op_o = aao_pkg::ALU_ADD;
    if (opcode_i[7:4] == aao_pkg::GRP_AND) begin
      op_o = aao_pkg::ALU_AND;
    end else if (opcode_i[7:4] != aao_pkg::GRP_ADD) begin
      legal_o = 1'b0;
    end
    mode_o = aao_pkg::MODE_WORK_WORK;
    len_o = aao_pkg::LEN_LONG;
    cycles_o = aao_pkg::CYC_LONG;
    dst_addr_o = byte3_i;
    src_addr_o = byte2_i;
    // Form from the low nibble, lengths and cycles per form
    case (opcode_i[3:0])
      aao_pkg::FORM_RR: begin
        mode_o = aao_pkg::MODE_WORK_WORK;
        len_o = aao_pkg::LEN_SHORT;
        cycles_o = aao_pkg::CYC_SHORT;
        dst_addr_o = {4'h0, byte2_i[7:4]};
        src_addr_o = {4'h0, byte2_i[3:0]};
      end
      aao_pkg::FORM_RIR: begin
        mode_o = aao_pkg::MODE_WORK_IND;
        len_o = aao_pkg::LEN_SHORT;
        dst_addr_o = {4'h0, byte2_i[7:4]};
        src_addr_o = {4'h0, byte2_i[3:0]};
      end
      aao_pkg::FORM_GG: mode_o = aao_pkg::MODE_REG_REG;
      aao_pkg::FORM_GIG: mode_o = aao_pkg::MODE_REG_IND;
      aao_pkg::FORM_GIM: begin
        mode_o = aao_pkg::MODE_REG_IMM;
        dst_addr_o = byte2_i;
        src_addr_o = aao_pkg::RST_BYTE;
      end
      default: legal_o = 1'b0;
    endcase
  end

endmodule

// ===== hw/aao_alu.sv
// Combining logic and flag updates for add and logical AND
`timescale 1ns/1ps
module aao_alu (
  // Operands
  input wire aao_pkg::aao_op_e op_i,
  input wire logic [7:0] dst_i,
  input wire logic [7:0] src_i,
  input wire logic [7:0] flags_i,
  // Results
  output logic [7:0] result_o,
  output logic [7:0] flags_o
);

  logic [8:0] sum;
  logic [4:0] low_sum;

  // ==========================================================
  // Full and low-nibble sums
  assign sum = {1'b0, dst_i} + {1'b0, src_i};
  assign low_sum = {1'b0, dst_i[3:0]} + {1'b0, src_i[3:0]};

  // Result and flags per operation
  always_comb begin
    flags_o = flags_i;
    if (op_i == aao_pkg::ALU_ADD) begin
      result_o = sum[7:0];
      flags_o[aao_pkg::FLG_C] = sum[8];
      flags_o[aao_pkg::FLG_Z] = (sum[7:0] == 8'h00);
      flags_o[aao_pkg::FLG_S] = sum[7];
      flags_o[aao_pkg::FLG_V] = (dst_i[7] == src_i[7]) && (sum[7] != dst_i[7]);
      flags_o[aao_pkg::FLG_D] = 1'b0;
      flags_o[aao_pkg::FLG_H] = low_sum[4];
    end else begin
      result_o = dst_i & src_i;
      flags_o[aao_pkg::FLG_Z] = ((dst_i & src_i) == 8'h00);
      flags_o[aao_pkg::FLG_S] = dst_i[7] & src_i[7];
      flags_o[aao_pkg::FLG_V] = 1'b0;
    end
  end

endmodule

// ===== verification/aao_core_monitor.sv
// Concurrent checks on the add/AND slice ports
`timescale 1ns/1ps
module aao_core_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Bus side
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // Sequencer status
  input wire logic busy_o,
  input wire logic done_o
);
  logic wr_q;
  logic rd_q;
  logic [7:0] adr_q;
  logic go;
  logic [7:0] op;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // Address phase capture
  always_ff @(posedge clk_i) begin
    wr_q <= rst_b_i && hsel_i && hready_i && htrans_i[1] && hwrite_i && hsize_i == 3'h2;
    rd_q <= rst_b_i && hsel_i && hready_i && htrans_i[1] && !hwrite_i;
    adr_q <= haddr_i[7:0];
  end
  // Start request seen in the data phase
  assign go = wr_q && adr_q == aao_pkg::OFS_CTRL && hwdata_i[8] && !busy_o;
  assign op = hwdata_i[7:0];
  // ==========================================================
  // Execution spans
  sequence s_run4;
    busy_o [*4] ##1 (!busy_o && done_o);
  endsequence
  sequence s_run6;
    busy_o [*6] ##1 (!busy_o && done_o);
  endsequence
  AST_ADD_SHORT: assert property (go && op == 8'h02 |=> s_run4)
    else $error("add short form span wrong");
  AST_ADD_LONG: assert property (go && op inside {[8'h03:8'h06]} |=> s_run6)
    else $error("add long form span wrong");
  AST_AND_SHORT: assert property (go && op == 8'h52 |=> s_run4)
    else $error("and short form span wrong");
  AST_AND_LONG: assert property (go && op inside {[8'h53:8'h56]} |=> s_run6)
    else $error("and long form span wrong");
  AST_ILLEGAL: assert property (go && !(op inside {[8'h02:8'h06], [8'h52:8'h56]})
    |=> busy_o ##1 (!busy_o && done_o))
    else $error("unknown opcode span wrong");
  AST_IDLE: assert property (!busy_o && !go |=> !busy_o)
    else $error("busy without start");
  AST_DONE_HOLD: assert property ($fell(done_o) |-> busy_o)
    else $error("done dropped without start");
  AST_UNMAPPED: assert property (rd_q && adr_q >= 8'h18 |-> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_OKAY: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready okay");
endmodule
bind aao_core aao_core_monitor mon_u (.clk_i, .rst_b_i, .hsel_i, .haddr_i, .htrans_i,
  .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .busy_o,
  .done_o);

// ===== verification/aao_host_bfm.sv
// Bus master model standing in for the host that drives the core over AHB-Lite
`timescale 1ns/1ps
module aao_host_bfm (
  // Clock and bus answer
  input wire logic clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  // Bus request
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  // ==========================================================
  // Idle bus at time zero
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
  end
  // One single word transfer, held until ready
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel_o <= 1'b1;
    haddr_o <= {24'h0, a};
    htrans_o <= 2'h2;
    hwrite_o <= w;
    @(posedge clk_i);
    while (hready_i !== 1'b1) @(posedge clk_i);
    htrans_o <= 2'h0;
    hwdata_o <= d;
    @(posedge clk_i);
    while (hready_i !== 1'b1) @(posedge clk_i);
    q = hrdata_i;
    hwdata_o <= ~d; // Released data no longer shows the word
  endtask
endmodule

// ===== verification/test_add_and_alu_ops.sv
// Self-checking bench for the add/AND slice
`timescale 1ns/1ps
module test_add_and_alu_ops;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic hsel, hwrite, hready, hresp, busy, done;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int mismatches = 0;
  int n_compared = 0;
  // ==========================================================
  // Design, bus master and clock
  aao_core dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .busy_o(busy), .done_o(done));
  aao_host_bfm bfm_u (.clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
    .hwdata_o(hwdata));
  initial forever #25 clk_i = ~clk_i;
  // ==========================================================
  // Compare, close, bus shorthands
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bfm_u.xfer(1'b1, a, d, q);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] q);
    bfm_u.xfer(1'b0, a, 32'h0, q);
  endtask
  // Run one instruction and check result, flags, operands and decode
  task exec(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s,
    input logic [7:0] f0);
    logic [31:0] r;
    logic [8:0] sum;
    logic [7:0] sv, res, fe;
    logic wk;
    int n;
    wr(aao_pkg::OFS_FLAGS, {24'h0, f0});
    wr(aao_pkg::OFS_OPND, {16'h0, s, d});
    wr(aao_pkg::OFS_INSTR, 32'h2534);
    wr(aao_pkg::OFS_CTRL, {23'h0, 1'b1, op});
    wr(aao_pkg::OFS_OPND, 32'hFFFF); // Ignored while busy
    n = 0;
    do begin
      rd(aao_pkg::OFS_STATUS, r);
      n++;
    end while (r[1] !== 1'b1 && n < 20);
    chk("done", r[1:0], 2'h2);
    sv = (op[3:0] == aao_pkg::FORM_GIM) ? 8'h25 : s;
    sum = d + sv;
    wk = op[3:0] <= aao_pkg::FORM_RIR;
    // Flag byte is C Z S V D H then two spare bits
    if (op[7:4] == aao_pkg::GRP_ADD) begin
      res = sum[7:0];
      fe = {sum[8], res == 8'h0, res[7], d[7] == sv[7] && res[7] != d[7], 1'b0,
        ({1'b0, d[3:0]} + sv[3:0]) > 5'hF, f0[1:0]};
    end else begin
      res = d & sv;
      fe = {f0[7], res == 8'h0, res[7], 1'b0, f0[3:0]};
    end
    rd(aao_pkg::OFS_RESULT, r);
    chk("result", r, {24'h0, res});
    rd(aao_pkg::OFS_FLAGS, r);
    chk("flags", r, {24'h0, fe});
    rd(aao_pkg::OFS_OPND, r);
    chk("operands", r, {16'h0, s, res});
    rd(aao_pkg::OFS_CTRL, r);
    chk("opcode", r, {24'h0, op});
    rd(aao_pkg::OFS_STATUS, r);
    chk("decode", r[11:0], {op[3:0] == aao_pkg::FORM_RR ? aao_pkg::CYC_SHORT :
      aao_pkg::CYC_LONG, 2'h0, wk ? aao_pkg::LEN_SHORT : aao_pkg::LEN_LONG, wk, 3'h2});
    chk("addresses", r[31:16], wk ? 16'h0403 :
      op[3:0] == aao_pkg::FORM_GIM ? 16'h0034 : 16'h3425);
  endtask
  // ==========================================================
  // Opcode table with operands that reach every flag case
  logic [7:0] ops [10] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56};
  logic [7:0] dv [10] = '{8'h7F, 8'hFF, 8'h80, 8'h12, 8'h00, 8'h12, 8'hF0, 8'h80, 8'h21, 8'hDA};
  logic [7:0] sr [10] = '{8'h01, 8'h01, 8'h80, 8'h03, 8'h55, 8'h03, 8'h0F, 8'hC0, 8'h03, 8'h55};
  initial begin
    logic [31:0] r;
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 6; i++) begin
      rd(8'h00 + 8'(4 * i), r);
      // Opcode 00 is undecodable, so STATUS shows the default long form
      chk("reset value", r, (i == 5) ?
        {20'h0, aao_pkg::CYC_LONG, 2'h0, aao_pkg::LEN_LONG, 4'h8} : 32'h0);
    end
    for (int i = 0; i < 10; i++) exec(ops[i], dv[i], sr[i], i[0] ? 8'hFF : 8'h00);
    exec(8'h02, 8'h88, 8'h88, 8'hFF);
    wr(aao_pkg::OFS_CTRL, 32'h0107);
    repeat (3) rd(aao_pkg::OFS_STATUS, r);
    chk("illegal status", r[2:0], 3'h6);
    rd(8'h20, r);
    chk("unmapped read", r, 32'h0);
    test_done;
  end
  // Watchdog against a hung transfer or wait
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    test_done;
  end
endmodule
